// file: src/rtc_timer_pkg.sv
// Package for the RTC countdown timer and interrupt status block.
// Assumes a single 100 MHz clock and a plain strobe register port.
package rtc_timer_pkg;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1C; // Mask register
   localparam logic [7:0] ADDR_RAW_STATUS = 8'h20;
   localparam logic [7:0] ADDR_MASKED_STATUS = 8'h24;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h28;
   localparam logic [7:0] ADDR_TIMER_VALUE = 8'h2C;
   localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h30;
   localparam logic [7:0] ADDR_FIRST_RELOAD = 8'h34;
   localparam logic [7:0] ADDR_SECOND_RELOAD = 8'h38;
   localparam logic [7:0] ADDR_PATTERN_FIRST = 8'h3C;
   localparam logic [7:0] ADDR_PATTERN_LAST = 8'h48;
   localparam logic [7:0] ADDR_EXPIRY_COUNT = 8'h4C;
   localparam int BIT_WATCH = 0;
   localparam int BIT_TIMER = 1;
   localparam int BIT_SINGLE_RUN = 0;
   localparam int BIT_EN = 1;
   localparam int BIT_SELF = 2;
   localparam int PATLEN_LO = 4;
   localparam int PATLEN_HI = 10;
   localparam int BIT_CLKSEL = 11;
   localparam int BIT_GATE = 12;
   localparam logic [31:0] CONTROL_MASK = 32'h0000_1FF7;
   localparam logic [31:0] TIMER_VALUE_RESET = 32'h0FFF_FFFF;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;

   // One register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
endpackage

// file: src/rtc_timer_irq_status.sv
// Countdown timer with raw, masked and clear interrupt status registers.
// Assumes tick inputs synchronous to clk, one-cycle pulses.
//
// Behaviour
// - Raw status bit 0 shows clockwatch interrupt before masking.
// - Raw status bit 1 shows timer interrupt before masking.
// - Masked status bit 0 shows gated clockwatch interrupt, drives its line.
// - Masked status bit 1 shows gated timer interrupt, drives its line.
// - Writing 1 to clear bit 0 clears clockwatch pending; 0 does nothing.
// - Writing 1 to clear bit 1 clears timer pending; 0 does nothing.
// - Periodic mode: at zero raise interrupt and reload from load value.
// - One-shot mode: at zero raise interrupt and stop counting.
// - Timer starts or stops on the next selected tick after enable changes.
// - Stopped counter holds its value unless the first load register is written; enable reads back current value.
// - Writing a load register while stopped sets the enable bit.
// - One-shot mode clears enable when counter reaches zero.
// - Self-start set: each load or pattern write sets enable.
// - Seven-bit pattern size sets how many pattern bits the pointer steps.
// - Clock select bit 11 picks slow reference or trimmed tick.
// - Gate override bit 12 keeps the timer clock always enabled.
// - Clockwatch mask bit passes or blocks clockwatch interrupt.
// - Timer mask bit passes or blocks timer interrupt.
// - Reload count comes from a writable 32-bit first load register.
`timescale 1ns/100ps
module rtc_timer_irq_status
   import rtc_timer_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   // Time bases and clockwatch event
   input wire logic slowRefTick,
   input wire logic trimTick,
   input wire logic watchEvent,
   // Interrupt lines and timer state
   output logic watchIrqLine,
   output logic timerIrqLine,
   output logic timerGatedClkEn,
   output logic patternBit
);
   reg_req_t req;
   logic [1:0] rawFlags;
   logic [1:0] irqEnable;
   logic [31:0] timerValue;
   logic [31:0] timerControl;
   logic [31:0] firstReload;
   logic [31:0] secondReload;
   logic [127:0] pattern;
   logic [6:0] patPtr;
   logic [31:0] irqCount;
   logic runState;
   logic [31:0] next_rdata;

   assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

   // Pattern word index from a byte address; shared by write and read paths
   function automatic logic [1:0] pat_word(input logic [7:0] addr);
      pat_word = addr[3:2] - 2'h3;
   endfunction

   // Register decode
   wire wrMask = req.wr && req.addr == ADDR_IRQ_ENABLE;
   wire wrClear = req.wr && req.addr == ADDR_IRQ_CLEAR;
   wire wrCtrl = req.wr && req.addr == ADDR_TIMER_CONTROL;
   wire wrLoad1 = req.wr && req.addr == ADDR_FIRST_RELOAD;
   wire wrLoad2 = req.wr && req.addr == ADDR_SECOND_RELOAD;
   wire wrPat = req.wr && req.addr >= ADDR_PATTERN_FIRST && req.addr <= ADDR_PATTERN_LAST
      && req.addr[1:0] == 2'b00;
   wire wrLoad = wrLoad1 || wrLoad2;
   wire singleRunSelect = timerControl[BIT_SINGLE_RUN];
   wire enableBit = timerControl[BIT_EN];
   wire selfStart = timerControl[BIT_SELF];
   wire [6:0] patternLength = timerControl[PATLEN_HI:PATLEN_LO];
   // Pointer wraps after length bits; a length of zero pins it at bit 0
   wire [6:0] ptrNext = patPtr + 7'h01;
   wire clkSelect = timerControl[BIT_CLKSEL];
   wire gateOverride = timerControl[BIT_GATE];

   // Timer tick source and gating
   wire selTick = clkSelect ? trimTick : slowRefTick;
   assign timerGatedClkEn = gateOverride | runState;
   wire countTick = selTick && runState;
   wire atZero = countTick && timerValue == ZERO32;
   wire timerEvent = atZero;

   // Masked view drives the lines
   wire [1:0] maskedFlags = rawFlags & irqEnable;
   assign watchIrqLine = maskedFlags[BIT_WATCH];
   assign timerIrqLine = maskedFlags[BIT_TIMER];

   // Enable set by load or self-start, cleared by one-shot expiry
   wire hwSetEn = (wrLoad && !runState) || (selfStart && (wrLoad || wrPat));
   wire hwClrEn = atZero && singleRunSelect;

   // Raw flags: set beats clear so no event is lost
   always_ff @(posedge clk) begin
      if (rst) begin
         rawFlags <= 2'b00;
      end else begin
         rawFlags[BIT_WATCH] <= watchEvent
            | (rawFlags[BIT_WATCH] & ~(wrClear & req.wdata[BIT_WATCH]));
         rawFlags[BIT_TIMER] <= timerEvent
            | (rawFlags[BIT_TIMER] & ~(wrClear & req.wdata[BIT_TIMER]));
      end
   end

   // Control, mask and load registers
   always_ff @(posedge clk) begin
      if (rst) begin
         timerControl <= ZERO32;
         irqEnable <= 2'b00;
         firstReload <= ZERO32;
         secondReload <= ZERO32;
         pattern <= '0;
      end else begin
         if (wrMask) irqEnable <= req.wdata[1:0];
         if (wrLoad1) firstReload <= req.wdata;
         if (wrLoad2) secondReload <= req.wdata;
         if (wrPat) pattern[{pat_word(req.addr), 5'h00} +: 32] <= req.wdata;
         if (wrCtrl) timerControl <= req.wdata & CONTROL_MASK;
         // Hardware wins over a same-cycle software write of enable
         if (hwClrEn) timerControl[BIT_EN] <= 1'b0;
         else if (hwSetEn) timerControl[BIT_EN] <= 1'b1;
      end
   end

   // Run state follows enable at the next selected tick
   always_ff @(posedge clk) begin
      if (rst) begin
         runState <= 1'b0;
      end else if (hwClrEn) begin
         runState <= 1'b0;
      end else if (selTick) begin
         runState <= enableBit;
      end
   end

   // Down counter; frozen while stopped except for a first load write
   always_ff @(posedge clk) begin
      if (rst) begin
         timerValue <= TIMER_VALUE_RESET;
         patPtr <= 7'h00;
         irqCount <= ZERO32;
      end else if (wrLoad1 && !runState) begin
         timerValue <= req.wdata;
      end else if (atZero) begin
         irqCount <= irqCount + 32'h0000_0001;
         if (!singleRunSelect) begin
            timerValue <= firstReload;
         end
         patPtr <= (ptrNext >= patternLength) ? 7'h00 : ptrNext;
      end else if (countTick) begin
         timerValue <= timerValue - 32'h0000_0001;
      end
   end

   // Pattern bit under the pointer
   always_ff @(posedge clk) begin
      if (rst) patternBit <= 1'b0;
      else patternBit <= pattern[patPtr];
   end

   // Read mux, answered one cycle later; unmapped reads as zero
   always_comb begin
      next_rdata = ZERO32;
      unique case (req.addr)
         ADDR_IRQ_ENABLE: next_rdata = {30'h0, irqEnable};
         ADDR_RAW_STATUS: next_rdata = {30'h0, rawFlags};
         ADDR_MASKED_STATUS: next_rdata = {30'h0, maskedFlags};
         ADDR_TIMER_VALUE: next_rdata = timerValue;
         ADDR_TIMER_CONTROL: next_rdata = timerControl;
         ADDR_FIRST_RELOAD: next_rdata = firstReload;
         ADDR_SECOND_RELOAD: next_rdata = secondReload;
         ADDR_EXPIRY_COUNT: next_rdata = irqCount;
         default: begin
            if (req.addr >= ADDR_PATTERN_FIRST && req.addr <= ADDR_PATTERN_LAST)
               next_rdata = pattern[{pat_word(req.addr), 5'h00} +: 32];
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) regRdata <= ZERO32;
      else if (req.rd) regRdata <= next_rdata;
      else regRdata <= ZERO32;
   end

   // Checks, all on the one clock; reset masks them
   // Expectations are spelled from the register map, not from the logic above

   // Watch line is raw AND enable
   chk_mask_and: assert property (@(posedge clk) disable iff (rst)
      watchIrqLine == (rawFlags[0] & irqEnable[0]))
      else $error("watch mask");

   // Timer line is raw AND enable
   chk_tmask_and: assert property (@(posedge clk) disable iff (rst)
      timerIrqLine == (rawFlags[1] & irqEnable[1]))
      else $error("timer mask");

   // Timer event always lands
   chk_set_wins: assert property (@(posedge clk) disable iff (rst)
      timerEvent |=> rawFlags[1])
      else $error("timer event lost");

   // Watch clear without a new event
   chk_watch_clear: assert property (@(posedge clk) disable iff (rst)
      wrClear && req.wdata[0] && !watchEvent |=> !rawFlags[0])
      else $error("no clear");

   // Zero in timer clear bit changes nothing
   chk_timer_clear: assert property (@(posedge clk) disable iff (rst)
      wrClear && !req.wdata[1] && rawFlags[1] |=> rawFlags[1])
      else $error("bad clear");

   // Periodic expiry reloads the first load value
   chk_reload_val: assert property (@(posedge clk) disable iff (rst)
      atZero && !singleRunSelect && !wrLoad1 |=> timerValue == $past(firstReload))
      else $error("no reload");

   // One-shot expiry stops and drops enable
   chk_oneshot_stop: assert property (@(posedge clk) disable iff (rst)
      atZero && singleRunSelect |=> !runState && !enableBit)
      else $error("no stop");

   // Stopped counter is frozen
   chk_frozen_count: assert property (@(posedge clk) disable iff (rst)
      !runState && !wrLoad1 |=> $stable(timerValue))
      else $error("count moved");

   // Load while stopped sets enable
   chk_load_sets_en: assert property (@(posedge clk) disable iff (rst)
      wrLoad && !runState && !hwClrEn |=> enableBit)
      else $error("en not set");

   // Enable takes effect at the next selected tick
   chk_start_tick: assert property (@(posedge clk) disable iff (rst)
      enableBit && selTick && !hwClrEn |=> runState)
      else $error("no start");

   // Watch event sets its raw bit
   chk_watch_set: assert property (@(posedge clk) disable iff (rst)
      watchEvent |=> rawFlags[BIT_WATCH])
      else $error("watch event lost");

   // Watch event beats a same-cycle clear
   chk_watch_race: assert property (@(posedge clk) disable iff (rst)
      wrClear && req.wdata[BIT_WATCH] && watchEvent |=> rawFlags[BIT_WATCH])
      else $error("watch race lost");

   // Watch raw bit sticks until cleared
   chk_watch_hold: assert property (@(posedge clk) disable iff (rst)
      rawFlags[BIT_WATCH] && !(wrClear && req.wdata[BIT_WATCH]) |=> rawFlags[BIT_WATCH])
      else $error("watch flag dropped");

   // Timer raw bit sticks until cleared
   chk_timer_hold: assert property (@(posedge clk) disable iff (rst)
      rawFlags[BIT_TIMER] && !(wrClear && req.wdata[BIT_TIMER]) |=> rawFlags[BIT_TIMER])
      else $error("timer flag dropped");

   // One in timer clear bit clears it
   chk_timer_wipe: assert property (@(posedge clk) disable iff (rst)
      wrClear && req.wdata[BIT_TIMER] && !timerEvent |=> !rawFlags[BIT_TIMER])
      else $error("timer not cleared");

   // Zero in watch clear bit changes nothing
   chk_watch_keep: assert property (@(posedge clk) disable iff (rst)
      wrClear && !req.wdata[BIT_WATCH] && rawFlags[BIT_WATCH] |=> rawFlags[BIT_WATCH])
      else $error("watch wrongly cleared");

   // Raw status read returns both raw bits
   chk_raw_read: assert property (@(posedge clk) disable iff (rst)
      req.rd && req.addr == ADDR_RAW_STATUS |=> regRdata == {30'h0, $past(rawFlags)})
      else $error("raw read wrong");

   // Masked status read returns gated bits
   chk_masked_read: assert property (@(posedge clk) disable iff (rst)
      req.rd && req.addr == ADDR_MASKED_STATUS |=> regRdata == {30'h0, $past(rawFlags & irqEnable)})
      else $error("masked read wrong");

   // Clear register is write-only and reads zero
   chk_clear_read: assert property (@(posedge clk) disable iff (rst)
      req.rd && req.addr == ADDR_IRQ_CLEAR |=> regRdata == ZERO32)
      else $error("clear read not zero");

   // Enable bit reads back its current value
   chk_enable_read: assert property (@(posedge clk) disable iff (rst)
      req.rd && req.addr == ADDR_TIMER_CONTROL |=> regRdata[BIT_EN] == $past(enableBit))
      else $error("enable read wrong");

   // Self-start pattern write sets enable
   chk_self_pattern: assert property (@(posedge clk) disable iff (rst)
      selfStart && wrPat && !hwClrEn |=> enableBit)
      else $error("pattern no start");

   // Self-start load write sets enable
   chk_self_load: assert property (@(posedge clk) disable iff (rst)
      selfStart && wrLoad && !hwClrEn |=> enableBit)
      else $error("load no start");

   // Trimmed source ignores everything but its tick
   chk_trim_only: assert property (@(posedge clk) disable iff (rst)
      runState && clkSelect && !trimTick |=> $stable(timerValue))
      else $error("trim count moved");

   // Trimmed tick steps the count down
   chk_trim_step: assert property (@(posedge clk) disable iff (rst)
      runState && clkSelect && trimTick && timerValue != ZERO32
      |=> timerValue == $past(timerValue) - 32'h0000_0001)
      else $error("trim step wrong");

   // Slow tick steps the count down
   chk_slow_step: assert property (@(posedge clk) disable iff (rst)
      runState && !clkSelect && slowRefTick && timerValue != ZERO32
      |=> timerValue == $past(timerValue) - 32'h0000_0001)
      else $error("slow step wrong");

   // Override keeps the clock enable high
   chk_gate_override: assert property (@(posedge clk) disable iff (rst)
      gateOverride |-> timerGatedClkEn)
      else $error("gate override lost");

   // Gating active and stopped drops the enable
   chk_gate_active: assert property (@(posedge clk) disable iff (rst)
      !gateOverride && !runState |-> !timerGatedClkEn)
      else $error("gate not active");

   // First load register takes written data
   chk_first_reload: assert property (@(posedge clk) disable iff (rst)
      wrLoad1 |=> firstReload == $past(req.wdata))
      else $error("load value lost");

   // Pointer stays inside the pattern length
   chk_pattern_bound: assert property (@(posedge clk) disable iff (rst)
      atZero && patPtr < patternLength |=> patPtr < $past(patternLength))
      else $error("pointer past length");

   // Disable takes effect at the next selected tick
   chk_stop_tick: assert property (@(posedge clk) disable iff (rst)
      !enableBit && selTick |=> !runState)
      else $error("no stop on tick");

   // No start between ticks
   chk_no_early: assert property (@(posedge clk) disable iff (rst)
      !runState && !selTick |=> !runState)
      else $error("early start");

   // Periodic mode keeps running through expiry
   chk_periodic_run: assert property (@(posedge clk) disable iff (rst)
      atZero && !singleRunSelect && enableBit |=> runState)
      else $error("periodic stopped");

   // One-shot rests at zero
   chk_oneshot_zero: assert property (@(posedge clk) disable iff (rst)
      atZero && singleRunSelect |=> timerValue == ZERO32)
      else $error("one-shot moved");

   // Masked-off watch never reaches its line
   chk_watch_off: assert property (@(posedge clk) disable iff (rst)
      !irqEnable[BIT_WATCH] |-> !watchIrqLine)
      else $error("watch line leaks");

   // Masked-off timer never reaches its line
   chk_timer_off: assert property (@(posedge clk) disable iff (rst)
      !irqEnable[BIT_TIMER] |-> !timerIrqLine)
      else $error("timer line leaks");

   // Main scenarios
   cov_periodic: cover property (@(posedge clk) atZero && !singleRunSelect);
   cov_oneshot: cover property (@(posedge clk) atZero && singleRunSelect);
   cov_clear_race: cover property (@(posedge clk) timerEvent && wrClear);
   cov_self_start: cover property (@(posedge clk) selfStart && wrPat);
   cov_pattern_wrap: cover property (@(posedge clk) atZero && ptrNext >= patternLength);
endmodule // rtc_timer_irq_status

// file: sim/tb_top.sv
// Self-checking bench for the RTC countdown timer and interrupt status block.
// Assumes a single 100 MHz clock; the bench drives the register port and ticks itself.
`timescale 1ns/100ps
module tb_top
   import rtc_timer_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic slowRefTick = 1'b0;
   logic trimTick = 1'b0;
   logic watchEvent = 1'b0;
   logic [31:0] regRdata;
   logic watchIrqLine, timerIrqLine, timerGatedClkEn, patternBit;
   logic [31:0] val, prev;
   int fails = 0;
   int compares = 0;

   // Free-running 10 ns clock
   always #5 clk = ~clk;

   rtc_timer_irq_status dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .slowRefTick(slowRefTick),
      .trimTick(trimTick), .watchEvent(watchEvent), .watchIrqLine(watchIrqLine),
      .timerIrqLine(timerIrqLine), .timerGatedClkEn(timerGatedClkEn), .patternBit(patternBit));

   task automatic end_of_test();
      $display("Counts: compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Case equality so an unknown never matches
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask

   // One time base pulse, then a few idle cycles so its effect lands
   task automatic tick(input logic trim);
      @(posedge clk);
      if (trim) trimTick <= 1'b1;
      else slowRefTick <= 1'b1;
      @(posedge clk);
      trimTick <= 1'b0;
      slowRefTick <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // Tick until the timer raw flag shows, bounded
   task automatic wait_timer(input int bound, input logic trim);
      int n = 0;
      rd(ADDR_RAW_STATUS, val);
      while (val[BIT_TIMER] !== 1'b1 && n < bound) begin
         tick(trim);
         n++;
         rd(ADDR_RAW_STATUS, val);
      end
      if (val[BIT_TIMER] !== 1'b1) begin
         fails++;
         $display("CHECK FAILED timer expiry expected 1 seen 0");
         end_of_test();
      end
   endtask

   task automatic t_reset();
      rd(ADDR_RAW_STATUS, val); chk("raw status", ZERO32, val);
      rd(ADDR_MASKED_STATUS, val); chk("masked status", ZERO32, val);
      wr(ADDR_TIMER_VALUE, 32'h0000_1234);
      rd(ADDR_TIMER_VALUE, val); chk("timer value", TIMER_VALUE_RESET, val);
      rd(ADDR_TIMER_CONTROL, val); chk("control", ZERO32, val);
      rd(ADDR_IRQ_CLEAR, val); chk("clear readback", ZERO32, val);
      rd(8'hF0, val); chk("unmapped", ZERO32, val);
      $display("test reset done");
   endtask

   task automatic t_watch();
      @(posedge clk) watchEvent <= 1'b1;
      @(posedge clk) watchEvent <= 1'b0;
      rd(ADDR_RAW_STATUS, val); chk("raw watch", 32'h1, val);
      rd(ADDR_MASKED_STATUS, val); chk("masked watch off", ZERO32, val);
      chk("watch line off", 32'h0, {31'h0, watchIrqLine});
      wr(ADDR_IRQ_ENABLE, 32'h1);
      rd(ADDR_MASKED_STATUS, val); chk("masked watch on", 32'h1, val);
      chk("watch line on", 32'h1, {31'h0, watchIrqLine});
      wr(ADDR_IRQ_CLEAR, 32'h2);
      rd(ADDR_RAW_STATUS, val); chk("raw watch kept", 32'h1, val);
      wr(ADDR_IRQ_CLEAR, 32'h1);
      rd(ADDR_RAW_STATUS, val); chk("raw watch cleared", ZERO32, val);
      // Clear and a fresh event in one cycle
      @(posedge clk);
      regAddr <= ADDR_IRQ_CLEAR;
      regWdata <= 32'h1;
      regWr <= 1'b1;
      watchEvent <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      watchEvent <= 1'b0;
      rd(ADDR_RAW_STATUS, val); chk("event beats clear", 32'h1, val);
      wr(ADDR_IRQ_CLEAR, 32'h1);
      wr(ADDR_IRQ_ENABLE, 32'h0);
      $display("test watch done");
   endtask

   task automatic t_oneshot();
      wr(ADDR_TIMER_CONTROL, 32'h1);
      wr(ADDR_FIRST_RELOAD, 32'h3);
      rd(ADDR_TIMER_CONTROL, val); chk("load sets enable", 32'h3, val);
      rd(ADDR_TIMER_VALUE, val); chk("loaded count", 32'h3, val);
      wr(ADDR_IRQ_ENABLE, 32'h2);
      wait_timer(8, 1'b0);
      chk("timer line", 32'h1, {31'h0, timerIrqLine});
      rd(ADDR_TIMER_CONTROL, val); chk("one-shot clears enable", 32'h1, val);
      rd(ADDR_TIMER_VALUE, prev);
      repeat (3) tick(1'b0);
      rd(ADDR_TIMER_VALUE, val); chk("stopped count frozen", prev, val);
      wr(ADDR_IRQ_CLEAR, 32'h2);
      rd(ADDR_RAW_STATUS, val); chk("raw timer cleared", ZERO32, val);
      chk("timer line cleared", 32'h0, {31'h0, timerIrqLine});
      $display("test one-shot done");
   endtask

   task automatic t_periodic();
      wr(ADDR_TIMER_CONTROL, 32'h0);
      wr(ADDR_FIRST_RELOAD, 32'h2);
      wait_timer(8, 1'b0);
      wr(ADDR_IRQ_CLEAR, 32'h2);
      wait_timer(8, 1'b0);
      rd(ADDR_TIMER_CONTROL, val); chk("periodic keeps enable", 32'h2, val);
      wr(ADDR_TIMER_CONTROL, 32'h0);
      tick(1'b0);
      rd(ADDR_TIMER_VALUE, prev);
      repeat (2) tick(1'b0);
      rd(ADDR_TIMER_VALUE, val); chk("disabled count frozen", prev, val);
      chk("gate off when stopped", 32'h0, {31'h0, timerGatedClkEn});
      wr(ADDR_IRQ_CLEAR, 32'h2);
      $display("test periodic done");
   endtask

   task automatic t_clksel();
      wr(ADDR_TIMER_CONTROL, 32'h0000_0800);
      wr(ADDR_FIRST_RELOAD, 32'h4);
      repeat (3) tick(1'b0);
      rd(ADDR_TIMER_VALUE, val); chk("slow tick ignored", 32'h4, val);
      wait_timer(10, 1'b1);
      wr(ADDR_TIMER_CONTROL, 32'h0000_1000);
      @(posedge clk) #1 chk("gate override", 32'h1, {31'h0, timerGatedClkEn});
      wr(ADDR_TIMER_CONTROL, 32'h0);
      tick(1'b0);
      chk("gate active", 32'h0, {31'h0, timerGatedClkEn});
      wr(ADDR_TIMER_CONTROL, 32'h0000_0070);
      rd(ADDR_TIMER_CONTROL, val); chk("pattern size field", 32'h0000_0070, val);
      wr(ADDR_TIMER_CONTROL, 32'h4);
      wr(ADDR_PATTERN_FIRST, 32'hFFFF_FFFF);
      rd(ADDR_TIMER_CONTROL, val); chk("self start", 32'h6, val);
      wr(ADDR_TIMER_CONTROL, 32'h0);
      wr(ADDR_IRQ_CLEAR, 32'h3);
      $display("test clock select and self start done");
   endtask

   // Pattern length 2 over bits 0..2 = 0,1,1: a pointer that overruns shows a 1
   task automatic t_pattern();
      wr(ADDR_TIMER_CONTROL, 32'h0000_0020);
      wr(ADDR_PATTERN_FIRST, 32'h0000_0006);
      wr(ADDR_SECOND_RELOAD, 32'h0000_00A5);
      rd(ADDR_TIMER_CONTROL, val); chk("second load sets enable", 32'h0000_0022, val);
      wr(ADDR_FIRST_RELOAD, 32'h1);
      @(posedge clk) #1 chk("pattern bit 0", 32'h0, {31'h0, patternBit});
      wait_timer(8, 1'b0);
      chk("pattern bit 1", 32'h1, {31'h0, patternBit});
      wr(ADDR_IRQ_CLEAR, 32'h2);
      wait_timer(8, 1'b0);
      chk("pattern wraps", 32'h0, {31'h0, patternBit});
      rd(ADDR_EXPIRY_COUNT, val); chk("expiry count", 32'h6, val);
      wr(ADDR_TIMER_CONTROL, 32'h0);
      tick(1'b0);
      wr(ADDR_IRQ_CLEAR, 32'h3);
      $display("test pattern done");
   endtask

   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_watch();
      t_oneshot();
      t_periodic();
      t_clksel();
      t_pattern();
      end_of_test();
   end
endmodule // tb_top
